// *** rtl/ccs_unit.sv ***
// common command handling and status reporting for the remote interface
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ccs_unit #(
    parameter logic [31:0] MAKER_CODE = 32'h0000_0a11, // arbitrary value
    parameter logic [31:0] MODEL_CODE = 32'h0000_0b22, // arbitrary value
    parameter logic [31:0] SERIAL_NUM = 32'h0000_0001,
    parameter logic [31:0] FW_DATE = 32'h0101_2000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // parsed commands
    input wire logic cmdValid,
    input wire logic [4:0] cmdCode,
    input wire logic cmdQuery,
    input wire logic [7:0] cmdParam,
    output logic cmdReady,
    // answers
    output logic respValid,
    output logic [1:0] respField,
    output logic [31:0] respData,
    // instrument side
    input wire logic opBusy,
    input wire logic [7:1] evtIn,
    input wire logic [4:0] sumLow,
    input wire logic sumHigh,
    input wire logic selfTestFail,
    output logic abortOps,
    output logic paramRestore,
    output logic factoryDefault,
    output logic datalogRun,
    output logic datalogStop,
    output logic srqOut,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // interrupt
    output logic irq
);
    ccs_pkg::ccs_state_t state_q, state_d;
    logic [7:0] eseQ, eseD, sreQ, sreD, esr;
    logic [1:0] idxQ, idxD;
    logic opcArm_q, opcArm_d;
    logic stResult_q, stCaught_q;
    logic [2:0] intEn_q, intEn_d, intStat;
    logic cmdReady_q, respValid_q, abortOps_q, paramRestore_q;
    logic factoryDefault_q, datalogRun_q, datalogStop_q, srqOut_q, irq_q;
    logic [1:0] respField_q;
    logic [31:0] respData_q, regRdata_q;

    // command decode
    wire logic take = cmdValid & cmdReady_q;
    wire logic isCls = cmdCode == ccs_pkg::CMD_CLS;
    wire logic isEse = cmdCode == ccs_pkg::CMD_ESE;
    wire logic isEsr = cmdCode == ccs_pkg::CMD_ESR;
    wire logic isIdn = cmdCode == ccs_pkg::CMD_IDN;
    wire logic isOpc = cmdCode == ccs_pkg::CMD_OPC;
    wire logic isRst = cmdCode == ccs_pkg::CMD_RST;
    wire logic isSre = cmdCode == ccs_pkg::CMD_SRE;
    wire logic isStb = cmdCode == ccs_pkg::CMD_STB;
    wire logic isTrg = cmdCode == ccs_pkg::CMD_TRG;
    wire logic isTst = cmdCode == ccs_pkg::CMD_TST;
    wire logic isWai = cmdCode == ccs_pkg::CMD_WAI;
    wire logic isLogRun = cmdCode == ccs_pkg::CMD_DATALOG_RUN;
    wire logic isFactDef = cmdCode == ccs_pkg::CMD_FACTORY_DEFAULT;
    // the wait command is known but triggers nothing
    wire logic known = isCls | isEse | isEsr | isIdn | isOpc | isRst
        | isSre | isStb | isTrg | isTst | isWai | isLogRun
        | isFactDef;
    wire logic qryOnly = isEsr | isIdn | isStb | isTst;
    wire logic qryAble = qryOnly | isEse | isSre | isOpc;
    // bare query forms and unknown names fall out here
    wire logic accept = take & known
        & (cmdQuery ? qryAble : ~qryOnly);
    wire logic qry = accept & cmdQuery;
    wire logic cmd = accept & ~cmdQuery;
    wire logic doCls = cmd & isCls;
    wire logic esrQry = qry & isEsr;
    wire logic logOn = cmdParam != 8'h00;

    // status composition
    wire logic esb = |(esr & eseQ);
    wire logic [7:0] stbSum = {sumHigh, 1'b0, esb, sumLow};
    wire logic reqSvc = |(stbSum & sreQ);
    wire logic [7:0] stb = {sumHigh, reqSvc, esb, sumLow};

    // completion tracking
    wire logic opcFire = opcArm_q & ~opBusy;
    wire logic [7:0] esrSet = {evtIn, opcFire};
    wire logic esrClr = doCls | esrQry;

    ccs_sticky #(.W(8)) u_esr (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .set(esrSet),
        .clr({8{esrClr}}),
        .flags(esr)
    );

    assign opcArm_d = doCls ? 1'b0 : (cmd & isOpc) ? 1'b1
        : opcFire ? 1'b0 : opcArm_q;

    // register port decode
    wire logic wrEse = regWr & (regAddr == ccs_pkg::OFS_ESE);
    wire logic wrSre = regWr & (regAddr == ccs_pkg::OFS_SRE);
    wire logic wrIntEn = regWr & (regAddr == ccs_pkg::OFS_INT_EN);
    wire logic wrIntClr = regWr & (regAddr == ccs_pkg::OFS_INT_CLR);
    assign eseD = (cmd & isEse) ? cmdParam
        : wrEse ? regWdata[7:0] : eseQ;
    assign sreD = (cmd & isSre) ? cmdParam
        : wrSre ? regWdata[7:0] : sreQ;
    assign intEn_d = wrIntEn ? regWdata[2:0] : intEn_q;
    wire logic [31:0] rdMux =
        (regAddr == ccs_pkg::OFS_ESR) ? {24'h0, esr}
        : (regAddr == ccs_pkg::OFS_ESE) ? {24'h0, eseQ}
        : (regAddr == ccs_pkg::OFS_SRE) ? {24'h0, sreQ}
        : (regAddr == ccs_pkg::OFS_STB) ? {24'h0, stb}
        : (regAddr == ccs_pkg::OFS_INT_STAT) ? {29'h0, intStat}
        : (regAddr == ccs_pkg::OFS_INT_EN) ? {29'h0, intEn_q}
        : 32'h0;

    // answer selection
    wire logic immHit = qry & (isEse | isEsr | isSre | isStb | isTst);
    wire logic [7:0] immVal = isEse ? eseQ
        : isEsr ? esr
        : isSre ? sreQ
        : isStb ? stb
        : {7'h0, stResult_q};
    wire logic [31:0] idnWord = (idxQ == 2'h0) ? MAKER_CODE
        : (idxQ == 2'h1) ? MODEL_CODE
        : (idxQ == 2'h2) ? SERIAL_NUM : FW_DATE;
    wire logic inIdn = state_q == ccs_pkg::ST_IDN;
    wire logic opcDone = (state_q == ccs_pkg::ST_OPC_WAIT) & ~opBusy;
    wire logic respD = immHit | opcDone | inIdn;
    wire logic [31:0] respDataD = inIdn ? idnWord
        : opcDone ? ccs_pkg::OPC_ANSWER
        : immHit ? {24'h0, immVal} : 32'h0;

    always_comb begin
        state_d = state_q;
        idxD = 2'h0;
        unique case (state_q)
            ccs_pkg::ST_IDLE: begin
                if (qry & isOpc) begin
                    state_d = ccs_pkg::ST_OPC_WAIT;
                end else if (qry & isIdn) begin
                    state_d = ccs_pkg::ST_IDN;
                end
            end
            ccs_pkg::ST_OPC_WAIT: begin
                if (!opBusy) begin
                    state_d = ccs_pkg::ST_IDLE;
                end
            end
            ccs_pkg::ST_IDN: begin
                idxD = idxQ + 2'h1;
                if (idxQ == ccs_pkg::IDN_LAST) begin
                    state_d = ccs_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // interrupt events
    wire logic [2:0] intSet = {respD, reqSvc & ~srqOut_q, opcFire};

    ccs_sticky #(.W(ccs_pkg::INT_W)) u_int (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .set(intSet),
        .clr(wrIntClr ? regWdata[2:0] : 3'h0),
        .flags(intStat)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ccs_pkg::ST_IDLE;
            idxQ <= 2'h0;
            opcArm_q <= 1'b0;
            cmdReady_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idxQ <= idxD;
            opcArm_q <= opcArm_d;
            cmdReady_q <= state_d == ccs_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            eseQ <= ccs_pkg::ESE_RST;
            sreQ <= ccs_pkg::SRE_RST;
            intEn_q <= ccs_pkg::INT_EN_RST;
        end else begin
            eseQ <= eseD;
            sreQ <= sreD;
            intEn_q <= intEn_d;
        end
    end

    // power-up test result is caught once after reset release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stCaught_q <= 1'b0;
            stResult_q <= 1'b0;
        end else if (!stCaught_q) begin
            stCaught_q <= 1'b1;
            stResult_q <= selfTestFail;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            respValid_q <= 1'b0;
            respField_q <= 2'h0;
            respData_q <= 32'h0;
        end else begin
            respValid_q <= respD;
            respField_q <= inIdn ? idxQ : 2'h0;
            respData_q <= respDataD;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            abortOps_q <= 1'b0;
            paramRestore_q <= 1'b0;
            factoryDefault_q <= 1'b0;
            datalogRun_q <= 1'b0;
            datalogStop_q <= 1'b0;
        end else begin
            abortOps_q <= doCls;
            paramRestore_q <= cmd & isRst;
            factoryDefault_q <= cmd & isFactDef
                & (cmdParam == ccs_pkg::FACTORY_KEY);
            datalogRun_q <= cmd & (isTrg | (isLogRun & logOn));
            datalogStop_q <= cmd & isLogRun & ~logOn;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            srqOut_q <= 1'b0;
            irq_q <= 1'b0;
            regRdata_q <= 32'h0;
        end else begin
            srqOut_q <= reqSvc;
            irq_q <= |(intStat & intEn_q);
            regRdata_q <= regRd ? rdMux : 32'h0;
        end
    end

    assign cmdReady = cmdReady_q;
    assign respValid = respValid_q;
    assign respField = respField_q;
    assign respData = respData_q;
    assign abortOps = abortOps_q;
    assign paramRestore = paramRestore_q;
    assign factoryDefault = factoryDefault_q;
    assign datalogRun = datalogRun_q;
    assign datalogStop = datalogStop_q;
    assign srqOut = srqOut_q;
    assign regRdata = regRdata_q;
    assign irq = irq_q;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_CLS_CLEARS: assert property (
        doCls && esrSet == 8'h00 |=> esr == 8'h00 && abortOps && !opcArm_q)
        else $error("clear left status or pending work");
    AST_ESB_FOLLOWS: assert property (
        qry && isStb && |(esr & eseQ) |=> respData[ccs_pkg::STB_ESB_BIT])
        else $error("summary bit missing");
    AST_LATCH_HOLD: assert property (
        !esrClr |=> (esr & $past(esr)) == $past(esr))
        else $error("event bit dropped without clear");
    AST_ESR_READ: assert property (
        esrQry && esrSet == 8'h00 |=> respValid
            && respData[7:0] == $past(esr) && esr == 8'h00)
        else $error("status query answer or clear wrong");
    AST_IDN_SEQ: assert property (
        qry && isIdn |=> !cmdReady ##1 respData == MAKER_CODE
            ##1 respData == MODEL_CODE ##1 respData == SERIAL_NUM
            ##1 respData == FW_DATE && respField == 2'h3)
        else $error("identity fields out of order");
    AST_OPC_BIT: assert property (
        opcArm_q && !opBusy && !esrClr |=> esr[ccs_pkg::ESR_OPC_BIT])
        else $error("completion bit not set");
    AST_OPC_HOLD: assert property (
        state_q == ccs_pkg::ST_OPC_WAIT && opBusy |=> !cmdReady && !respValid)
        else $error("completion query released early");
    AST_OPC_ANS: assert property (
        opcDone |=> respValid && respData == ccs_pkg::OPC_ANSWER)
        else $error("completion query answer wrong");
    AST_RST_ONLY: assert property (
        cmd && isRst |=> paramRestore && !factoryDefault)
        else $error("reset command misrouted");
    AST_SRQ: assert property (
        |(stbSum & sreQ) |=> srqOut)
        else $error("service request not raised");
    AST_STB_KEEP: assert property (
        qry && isStb |=> respData[ccs_pkg::STB_RQS_BIT] == srqOut)
        else $error("status byte query lost service bit");
    AST_TRG_RUN: assert property (
        cmd && isTrg |=> datalogRun && !datalogStop)
        else $error("trigger did not start datalog");
    AST_TST_ANS: assert property (
        qry && isTst |=> respData == {31'h0, stResult_q})
        else $error("self-test answer wrong");
    AST_DISCARD: assert property (
        take && !known |=> !respValid && $stable(eseQ) && $stable(sreQ))
        else $error("unknown command had an effect");
    AST_BARE_QRY: assert property (
        take && qryOnly && !cmdQuery |=> !respValid)
        else $error("bare query answered");

    COV_IDN: cover property (qry && isIdn ##5 cmdReady);
    COV_OPC_WAIT: cover property (
        state_q == ccs_pkg::ST_OPC_WAIT && opBusy ##1 opcDone);
    COV_SRQ: cover property (!srqOut ##1 srqOut);
    COV_CLS: cover property (opcArm_q && doCls);
endmodule

`default_nettype wire

// *** inc/ccs_pkg.sv ***
// constants shared by the common command and status unit
package ccs_pkg;
    // command codes delivered by the text parser
    localparam logic [4:0] CMD_CLS = 5'h01;
    localparam logic [4:0] CMD_ESE = 5'h02;
    localparam logic [4:0] CMD_ESR = 5'h03;
    localparam logic [4:0] CMD_IDN = 5'h04;
    localparam logic [4:0] CMD_OPC = 5'h05;
    localparam logic [4:0] CMD_RST = 5'h06;
    localparam logic [4:0] CMD_SRE = 5'h07;
    localparam logic [4:0] CMD_STB = 5'h08;
    localparam logic [4:0] CMD_TRG = 5'h09;
    localparam logic [4:0] CMD_TST = 5'h0a;
    localparam logic [4:0] CMD_WAI = 5'h0b;
    localparam logic [4:0] CMD_DATALOG_RUN = 5'h0c;
    localparam logic [4:0] CMD_FACTORY_DEFAULT = 5'h0d;
    // guard value the factory default command must carry
    localparam logic [7:0] FACTORY_KEY = 8'h63;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_ESR = 8'h00;
    localparam logic [7:0] OFS_ESE = 8'h04;
    localparam logic [7:0] OFS_SRE = 8'h08;
    localparam logic [7:0] OFS_STB = 8'h0c;
    localparam logic [7:0] OFS_INT_STAT = 8'h10;
    localparam logic [7:0] OFS_INT_EN = 8'h14;
    localparam logic [7:0] OFS_INT_CLR = 8'h18;

    // field positions
    localparam int ESR_OPC_BIT = 0;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_RQS_BIT = 6;
    localparam int INT_OPC_BIT = 0;
    localparam int INT_SRQ_BIT = 1;
    localparam int INT_RESP_BIT = 2;
    localparam int INT_W = 3;

    // reset values
    localparam logic [7:0] ESR_RST = 8'h00;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [2:0] INT_EN_RST = 3'h0;

    // identification answer layout and completion query answer
    localparam logic [1:0] IDN_LAST = 2'h3;
    localparam logic [31:0] OPC_ANSWER = 32'h0000_0001;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OPC_WAIT,
        ST_IDN
    } ccs_state_t;
endpackage

// *** rtl/ccs_sticky.sv ***
// bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module ccs_sticky #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // per-bit set and clear
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // latched flags
    output logic [W-1:0] flags
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic flag_q;
            logic flag_d;
            // a set bit ignores further sets until cleared
            assign flag_d = set[i] | (flag_q & ~clr[i]);
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    flag_q <= 1'b0;
                end else begin
                    flag_q <= flag_d;
                end
            end
            assign flags[i] = flag_q;
        end
    endgenerate
endmodule

`default_nettype wire

// *** verif/ccs_host_model.sv ***
// host-side source of parsed commands for the common command unit
`timescale 1ns/1ps
`default_nettype none

module ccs_host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // command port
    input wire logic cmdReady,
    output logic cmdValid,
    output logic [4:0] cmdCode,
    output logic cmdQuery,
    output logic [7:0] cmdParam
);
    initial begin
        cmdValid = 1'b0;
        cmdCode = 5'h00;
        cmdQuery = 1'b0;
        cmdParam = 8'h00;
    end

    // offer one command, hold it until the taking edge, then scramble
    task automatic send(input logic [4:0] code, input logic q,
                        input logic [7:0] prm);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdQuery <= q;
        cmdParam <= prm;
        do @(negedge clk_sys); while (cmdReady !== 1'b1 || arst_n !== 1'b1);
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        cmdCode <= ~code;
        cmdQuery <= ~q;
        cmdParam <= ~prm;
    endtask
endmodule

`default_nettype wire

// *** verif/ccs_unit_bench.sv ***
// self-checking bench for the common command and status unit
`timescale 1ns/1ps
`default_nettype none

module ccs_unit_bench;
    // identity values are arbitrary
    localparam logic [31:0] MAKER = 32'h0000_00c5;
    localparam logic [31:0] MODEL = 32'h0000_0d7e;
    localparam logic [31:0] SERIAL = 32'h0012_3456;
    localparam logic [31:0] FWDATE = 32'h0315_2021;
    logic clk_sys, arst_n, cmdValid, cmdQuery, cmdReady, respValid;
    logic opBusy, sumHigh, selfTestFail, abortOps, paramRestore;
    logic factoryDefault, datalogRun, datalogStop, srqOut, regWr, regRd, irq;
    logic [4:0] cmdCode, sumLow;
    logic [7:0] cmdParam, regAddr;
    logic [1:0] respField;
    logic [31:0] respData, regWdata, regRdata, rd;
    logic [7:1] evtIn;
    logic [33:0] respQ[$];
    int error_cnt, cmp_count, abortCnt, restoreCnt, factCnt, runCnt, stopCnt;

    ccs_unit #(.MAKER_CODE(MAKER), .MODEL_CODE(MODEL),
        .SERIAL_NUM(SERIAL), .FW_DATE(FWDATE)) i_ccs_unit (
        .clk_sys(clk_sys), .arst_n(arst_n), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdQuery(cmdQuery), .cmdParam(cmdParam),
        .cmdReady(cmdReady), .respValid(respValid), .respField(respField),
        .respData(respData), .opBusy(opBusy), .evtIn(evtIn),
        .sumLow(sumLow), .sumHigh(sumHigh), .selfTestFail(selfTestFail),
        .abortOps(abortOps), .paramRestore(paramRestore),
        .factoryDefault(factoryDefault), .datalogRun(datalogRun),
        .datalogStop(datalogStop), .srqOut(srqOut), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .irq(irq));

    ccs_host_model i_ccs_host_model (.clk_sys(clk_sys), .arst_n(arst_n),
        .cmdReady(cmdReady), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdQuery(cmdQuery), .cmdParam(cmdParam));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // collect answer words and count the one-cycle pulses
    always @(posedge clk_sys) begin
        if (respValid === 1'b1) respQ.push_back({respField, respData});
        if (abortOps === 1'b1) abortCnt++;
        if (paramRestore === 1'b1) restoreCnt++;
        if (factoryDefault === 1'b1) factCnt++;
        if (datalogRun === 1'b1) runCnt++;
        if (datalogStop === 1'b1) stopCnt++;
    end

    task automatic results;
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chkVal(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic doReset;
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (9) @(posedge clk_sys);
        arst_n <= 1'b1;
        idle(2);
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic regChk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 rd = regRdata;
        chkVal({2'h0, rd}, {2'h0, exp});
    endtask

    task automatic cmd(input logic [4:0] c, input logic q, input logic [7:0] p);
        i_ccs_host_model.send(c, q, p);
    endtask

    task automatic expResp(input logic [33:0] exp);
        int n;
        logic [33:0] got;
        n = 0;
        while (respQ.size() == 0 && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
        #1;
        if (respQ.size() != 0) got = respQ.pop_front();
        else got = 'x;
        chkVal(got, exp);
    endtask

    task automatic noResp;
        idle(8);
        chkVal(34'(respQ.size()), 34'h0);
    endtask

    task automatic evt(input logic [7:1] e);
        @(posedge clk_sys);
        evtIn <= e;
        @(posedge clk_sys);
        evtIn <= 7'h00;
    endtask

    task automatic t_reset;
        regChk(ccs_pkg::OFS_ESE, 32'h0);
        regChk(ccs_pkg::OFS_SRE, 32'h0);
        regChk(ccs_pkg::OFS_ESR, 32'h0);
        regChk(ccs_pkg::OFS_INT_EN, 32'h0);
        regChk(ccs_pkg::OFS_INT_CLR, 32'h0);
        regChk(8'h20, 32'h0);
        chkBit(irq, 1'b0);
        chkBit(cmdReady, 1'b1);
    endtask

    task automatic t_events;
        cmd(ccs_pkg::CMD_ESE, 1'b0, 8'h24);
        cmd(ccs_pkg::CMD_ESE, 1'b1, 8'h00);
        expResp(34'h24);
        evt(7'h02);
        cmd(ccs_pkg::CMD_STB, 1'b1, 8'h00);
        expResp(34'h20);
        evt(7'h02);
        evt(7'h06);
        regChk(ccs_pkg::OFS_ESR, 32'h0c);
        cmd(ccs_pkg::CMD_ESR, 1'b1, 8'h00);
        expResp(34'h0c);
        cmd(ccs_pkg::CMD_ESR, 1'b1, 8'h00);
        expResp(34'h00);
        cmd(ccs_pkg::CMD_STB, 1'b1, 8'h00);
        expResp(34'h00);
    endtask

    task automatic t_srq;
        cmd(ccs_pkg::CMD_SRE, 1'b0, 8'h81);
        cmd(ccs_pkg::CMD_SRE, 1'b1, 8'h00);
        expResp(34'h81);
        @(posedge clk_sys);
        sumLow <= 5'h02;
        idle(4);
        chkBit(srqOut, 1'b0);
        @(posedge clk_sys);
        sumLow <= 5'h01;
        idle(4);
        chkBit(srqOut, 1'b1);
        regChk(ccs_pkg::OFS_INT_STAT, 32'h6);
        chkBit(irq, 1'b0);
        regWrite(ccs_pkg::OFS_INT_EN, 32'h2);
        idle(3);
        chkBit(irq, 1'b1);
        cmd(ccs_pkg::CMD_STB, 1'b1, 8'h00);
        expResp(34'h41);
        idle(2);
        chkBit(srqOut, 1'b1);
        regWrite(ccs_pkg::OFS_INT_CLR, 32'h2);
        idle(3);
        chkBit(irq, 1'b0);
        regChk(ccs_pkg::OFS_INT_STAT, 32'h4);
        @(posedge clk_sys);
        sumLow <= 5'h00;
        idle(4);
        chkBit(srqOut, 1'b0);
        @(posedge clk_sys);
        sumHigh <= 1'b1;
        idle(4);
        chkBit(irq, 1'b1);
        @(posedge clk_sys);
        sumHigh <= 1'b0;
        regWrite(ccs_pkg::OFS_INT_EN, 32'h0);
        regWrite(ccs_pkg::OFS_INT_CLR, 32'h7);
        regWrite(ccs_pkg::OFS_SRE, 32'h5a);
        regChk(ccs_pkg::OFS_SRE, 32'h5a);
        regWrite(ccs_pkg::OFS_SRE, 32'h0);
    endtask

    task automatic t_opc;
        @(posedge clk_sys);
        opBusy <= 1'b1;
        cmd(ccs_pkg::CMD_OPC, 1'b0, 8'h00);
        idle(5);
        regChk(ccs_pkg::OFS_ESR, 32'h0);
        @(posedge clk_sys);
        opBusy <= 1'b0;
        idle(3);
        regChk(ccs_pkg::OFS_ESR, 32'h1);
        cmd(ccs_pkg::CMD_ESR, 1'b1, 8'h00);
        expResp(34'h1);
        @(posedge clk_sys);
        opBusy <= 1'b1;
        cmd(ccs_pkg::CMD_OPC, 1'b1, 8'h00);
        noResp;
        @(posedge clk_sys);
        opBusy <= 1'b0;
        expResp({2'h0, ccs_pkg::OPC_ANSWER});
        regChk(ccs_pkg::OFS_ESR, 32'h0);
    endtask

    task automatic t_cls;
        int n;
        n = abortCnt;
        evt(7'h08);
        @(posedge clk_sys);
        opBusy <= 1'b1;
        cmd(ccs_pkg::CMD_OPC, 1'b0, 8'h00);
        cmd(ccs_pkg::CMD_CLS, 1'b0, 8'h00);
        idle(3);
        chkVal(34'(abortCnt - n), 34'h1);
        @(posedge clk_sys);
        opBusy <= 1'b0;
        idle(4);
        regChk(ccs_pkg::OFS_ESR, 32'h0);
        cmd(ccs_pkg::CMD_ESE, 1'b1, 8'h00);
        expResp(34'h24);
    endtask

    task automatic t_idn;
        cmd(ccs_pkg::CMD_IDN, 1'b1, 8'h00);
        #1 chkBit(cmdReady, 1'b0);
        cmd(ccs_pkg::CMD_ESE, 1'b1, 8'h00);
        expResp({2'h0, MAKER});
        expResp({2'h1, MODEL});
        expResp({2'h2, SERIAL});
        expResp({2'h3, FWDATE});
        expResp(34'h24);
    endtask

    task automatic t_misc;
        int r;
        int f;
        int u;
        int s;
        r = restoreCnt;
        f = factCnt;
        u = runCnt;
        s = stopCnt;
        cmd(ccs_pkg::CMD_RST, 1'b0, 8'h00);
        cmd(ccs_pkg::CMD_FACTORY_DEFAULT, 1'b0, 8'h05);
        idle(3);
        chkVal(34'(restoreCnt - r), 34'h1);
        chkVal(34'(factCnt - f), 34'h0);
        cmd(ccs_pkg::CMD_FACTORY_DEFAULT, 1'b0, ccs_pkg::FACTORY_KEY);
        cmd(ccs_pkg::CMD_TRG, 1'b0, 8'h00);
        idle(3);
        chkVal(34'(factCnt - f), 34'h1);
        chkVal(34'(runCnt - u), 34'h1);
        cmd(ccs_pkg::CMD_DATALOG_RUN, 1'b0, 8'h01);
        cmd(ccs_pkg::CMD_DATALOG_RUN, 1'b0, 8'h00);
        idle(3);
        chkVal(34'(runCnt - u), 34'h2);
        chkVal(34'(stopCnt - s), 34'h1);
        cmd(ccs_pkg::CMD_TST, 1'b1, 8'h00);
        expResp(34'h0);
        cmd(ccs_pkg::CMD_WAI, 1'b0, 8'h00);
        noResp;
        evt(7'h01);
        cmd(5'h1f, 1'b0, 8'h00);
        cmd(5'h1f, 1'b1, 8'h00);
        cmd(ccs_pkg::CMD_RST, 1'b1, 8'h00);
        noResp;
        chkVal(34'(restoreCnt - r), 34'h1);
        cmd(ccs_pkg::CMD_ESR, 1'b0, 8'h00);
        noResp;
        cmd(ccs_pkg::CMD_ESR, 1'b1, 8'h00);
        expResp(34'h02);
        @(posedge clk_sys);
        selfTestFail <= 1'b1;
        doReset;
        cmd(ccs_pkg::CMD_TST, 1'b1, 8'h00);
        expResp(34'h1);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        results;
    end

    initial begin
        arst_n = 1'b0;
        opBusy = 1'b0;
        sumHigh = 1'b0;
        sumLow = 5'h00;
        selfTestFail = 1'b0;
        evtIn = 7'h00;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        doReset;
        t_reset;
        t_events;
        t_srq;
        t_opc;
        t_cls;
        t_idn;
        t_misc;
        results;
    end
endmodule

`default_nettype wire
